// [src/programmable_chip_select_decoder.sv]
`timescale 1ns/1ps
`include "chip_select_defines.svh"

module programmable_chip_select_decoder (
   input  wire                             clk,
   input  wire                             resetn,
   input  wire  chip_select_pkg::cfg_req_t cfgReq,
   input  wire  chip_select_pkg::isa_pins_t isaPins,
   output logic [7:0]                      cfgRdData,
   output logic                            cfgRdValid,
   output logic                            selectOutZeroN,
   output logic                            selectOutOneN,
   output logic                            selectOutTwoN
);

   // Whole block state; the pin synchroniser lives here too
   typedef struct packed {
      logic [3:0]                          index;
      chip_select_pkg::sel_regs_t [2:0]    sel;
      chip_select_pkg::isa_pins_t          pinMeta;
      chip_select_pkg::isa_pins_t          pinSync;
      logic [7:0]                          rdData;
      logic                                rdValid;
   } state_t;

   state_t stateQ;
   state_t stateD;
   logic [2:0] selectN;

   // Value of the register at a second-level index; holes read as zero
   function automatic logic [7:0] regValue(input chip_select_pkg::sel_regs_t [2:0] sel,
                                           input logic [3:0] idx);
      logic [7:0] val;
      val = `READ_PAD;
      for (int i = 0; i < `SEL_COUNT; i++) begin
         if (idx[3:2] == 2'(i)) begin
            case (idx[1:0])
               `SLOT_BASE_HIGH:     val = sel[i].baseHigh;
               `SLOT_BASE_LOW:      val = sel[i].baseLow;
               `SLOT_DECODE_CONFIG: val = sel[i].decodeConfig;
               default:             val = `READ_PAD;
            endcase
         end
      end
      return val;
   endfunction : regValue

   // Next-state logic: pin synchroniser, index register and data register port
   always_comb begin
      stateD = stateQ;
      // Bus pins are asynchronous to clk, so they pass two flops first
      stateD.pinMeta = isaPins;
      stateD.pinSync = stateQ.pinMeta;
      stateD.rdValid = 1'b0;
      if (cfgReq.write) begin
         if (cfgReq.index == `CS_INDEX_REG) begin
            // Only four bits are stored, so 10h and up can never be formed
            stateD.index = cfgReq.wrData[3:0];
         end else if (cfgReq.index == `CS_DATA_REG) begin
            for (int i = 0; i < `SEL_COUNT; i++) begin
               if (stateQ.index[3:2] == 2'(i)) begin
                  case (stateQ.index[1:0])
                     `SLOT_BASE_HIGH:     stateD.sel[i].baseHigh = cfgReq.wrData;
                     `SLOT_BASE_LOW:      stateD.sel[i].baseLow = cfgReq.wrData;
                     `SLOT_DECODE_CONFIG: stateD.sel[i].decodeConfig = cfgReq.wrData;
                     default:             stateD.sel[i] = stateQ.sel[i];
                  endcase
               end
            end
         end
      end
      // Reads see the state before any write in the same cycle
      if (cfgReq.read) begin
         stateD.rdValid = 1'b1;
         if (cfgReq.index == `CS_INDEX_REG) begin
            stateD.rdData = {4'h0, stateQ.index};
         end else if (cfgReq.index == `CS_DATA_REG) begin
            stateD.rdData = regValue(stateQ.sel, stateQ.index);
         end else begin
            stateD.rdData = `READ_PAD;
         end
      end
   end

   // Single register stage for the whole state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateQ.index   <= `INDEX_RESET;
         stateQ.sel     <= '0;
         stateQ.pinMeta <= '1;
         stateQ.pinSync <= '1;
         stateQ.rdData  <= `READ_PAD;
         stateQ.rdValid <= 1'b0;
      end else begin
         stateQ <= stateD;
      end
   end

   // Same decoder for each output, fed from the second synchroniser stage
   for (genvar g = 0; g < `SEL_COUNT; g++) begin : gDecode
      select_gate uGate (
         .pins    (stateQ.pinSync),
         .regs    (stateQ.sel[g]),
         .selectN (selectN[g])
      );
   end

   // Outputs; selects stay high through reset since the sync flops reset high
   assign selectOutZeroN = selectN[0];
   assign selectOutOneN  = selectN[1];
   assign selectOutTwoN  = selectN[2];
   assign cfgRdData      = stateQ.rdData;
   assign cfgRdValid     = stateQ.rdValid;

   // Index write lands in four bits only
   AST_INDEX_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index == `CS_INDEX_REG
      |=> stateQ.index == $past(cfgReq.wrData[3:0]))
      else $error("index register did not take the written nibble");

   // Data port read returns the addressed base low byte of output zero
   AST_DATA_READ: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.read && cfgReq.index == `CS_DATA_REG && stateQ.index == `SEL0_BASE_LOW
      |=> cfgRdValid && cfgRdData == $past(stateQ.sel[0].baseLow))
      else $error("data register read did not return base low of output zero");

   // Upper index bits always read zero
   AST_INDEX_UPPER: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.read && cfgReq.index == `CS_INDEX_REG
      |=> cfgRdValid && cfgRdData[7:4] == 4'h0)
      else $error("index register upper bits not zero");

   // Config of output one sits at 06h
   AST_WRITE_MAP: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index == `CS_DATA_REG && stateQ.index == `SEL1_DECODE_CONFIG
      |=> stateQ.sel[1].decodeConfig == $past(cfgReq.wrData))
      else $error("config of output one not written at its index");

   // Output two base high sits at 08h
   AST_WRITE_MAP2: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index == `CS_DATA_REG && stateQ.index == `SEL2_BASE_HIGH
      |=> stateQ.sel[2].baseHigh == $past(cfgReq.wrData))
      else $error("base high of output two not written at its index");

   // Registers hold zero while reset is applied
   AST_RESET_CLEAR: assert property (@(posedge clk)
      !resetn |-> stateQ.sel == '0 && stateQ.index == `INDEX_RESET)
      else $error("registers not clear during reset");

   // Writes to the holes leave every register untouched
   AST_HOLE_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index == `CS_DATA_REG && stateQ.index[1:0] == `SLOT_RESERVED
      |=> $stable(stateQ.sel))
      else $error("write to an empty index changed a register");

   // Address-enable high blocks every select
   AST_AEN_BLOCKS: assert property (@(posedge clk) disable iff (!resetn)
      stateQ.pinSync.aen |-> selectN == 3'b111)
      else $error("select asserted with address-enable high");

   // Bit 0 masks A0: addresses differing only there still hit
   AST_MASK_A0: assert property (@(posedge clk) disable iff (!resetn)
      !stateQ.pinSync.aen && stateQ.sel[0].decodeConfig[`CFG_ANY_STROBE]
      && stateQ.sel[0].decodeConfig[`CFG_MASK_A0]
      && stateQ.pinSync.addr[15:1] == {stateQ.sel[0].baseHigh, stateQ.sel[0].baseLow[7:1]}
      |-> !selectOutZeroN)
      else $error("A0 mask did not drop A0 from the compare");

   // Bit 7 masks A11-A0 so only the top nibble counts
   AST_MASK_LOW12: assert property (@(posedge clk) disable iff (!resetn)
      !stateQ.pinSync.aen && stateQ.sel[0].decodeConfig[`CFG_ANY_STROBE]
      && stateQ.sel[0].decodeConfig[`CFG_MASK_LOW12]
      && stateQ.pinSync.addr[15:12] == stateQ.sel[0].baseHigh[7:4]
      |-> !selectOutZeroN)
      else $error("A11-A0 mask did not drop the low lines");

   // Write strobe qualification of output zero
   AST_ON_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      chip_select_pkg::addrHit(stateQ.pinSync, stateQ.sel[0]) && !stateQ.pinSync.aen
      && !stateQ.sel[0].decodeConfig[`CFG_ANY_STROBE] && stateQ.pinSync.rdN
      && !stateQ.pinSync.wrN
      |-> selectOutZeroN == !stateQ.sel[0].decodeConfig[`CFG_ON_WRITE])
      else $error("write strobe qualification wrong");

   // Read strobe qualification of output zero
   AST_ON_READ: assert property (@(posedge clk) disable iff (!resetn)
      chip_select_pkg::addrHit(stateQ.pinSync, stateQ.sel[0]) && !stateQ.pinSync.aen
      && !stateQ.sel[0].decodeConfig[`CFG_ANY_STROBE] && stateQ.pinSync.wrN
      && !stateQ.pinSync.rdN
      |-> selectOutZeroN == !stateQ.sel[0].decodeConfig[`CFG_ON_READ])
      else $error("read strobe qualification wrong");

   // Bit 6 asserts on any match, strobes idle
   AST_ANY_STROBE: assert property (@(posedge clk) disable iff (!resetn)
      chip_select_pkg::addrHit(stateQ.pinSync, stateQ.sel[0]) && !stateQ.pinSync.aen
      && stateQ.sel[0].decodeConfig[`CFG_ANY_STROBE]
      |-> !selectOutZeroN)
      else $error("any-strobe mode did not assert on a match");

   // Output two follows the same decode as output zero
   AST_SAME_DECODE: assert property (@(posedge clk) disable iff (!resetn)
      stateQ.sel[2] == stateQ.sel[0] |-> selectOutTwoN == selectOutZeroN)
      else $error("output two decodes differently from output zero");

   // Quiet bus drives all selects high once the pins have been idle for two cycles
   AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!resetn)
      isaPins.rdN && isaPins.wrN && isaPins.aen
      ##1 isaPins.rdN && isaPins.wrN && isaPins.aen
      |=> selectN == 3'b111)
      else $error("select low while bus idle");

   // A mismatch in the top nibble never hits, whatever the mask bits
   AST_TOP_NIBBLE: assert property (@(posedge clk) disable iff (!resetn)
      stateQ.pinSync.addr[15:12] != stateQ.sel[1].baseHigh[7:4] |-> selectOutOneN)
      else $error("top address nibble ignored in compare");

   // Index read returns the stored nibble, not just zero upper bits
   AST_INDEX_READ: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.read && cfgReq.index == `CS_INDEX_REG
      |=> cfgRdData[3:0] == $past(stateQ.index))
      else $error("index register read returned a wrong nibble");

   // Valid is a single pulse that only a read request raises
   AST_RDVALID_PULSE: assert property (@(posedge clk) disable iff (!resetn)
      !cfgReq.read |=> !cfgRdValid)
      else $error("read valid without a read request");

   // Read data holds between reads, so software may sample it late
   AST_RDDATA_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !cfgReq.read |=> $stable(cfgRdData))
      else $error("read data changed without a read");

   // Foreign first-level indexes read as zero
   AST_RD_FOREIGN: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.read && cfgReq.index != `CS_INDEX_REG && cfgReq.index != `CS_DATA_REG
      |=> cfgRdData == 8'h00)
      else $error("foreign index read not zero");

   // The top group of second-level indexes holds no register
   AST_RD_TOPGROUP: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.read && cfgReq.index == `CS_DATA_REG && stateQ.index[3:2] == 2'h3
      |=> cfgRdData == 8'h00)
      else $error("empty index group read not zero");

   // Writes to foreign first-level indexes leave everything alone
   AST_OTHER_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index != `CS_INDEX_REG && cfgReq.index != `CS_DATA_REG
      |=> $stable(stateQ.sel) && $stable(stateQ.index))
      else $error("foreign index write changed state");

   // Registers only move on a write request
   AST_BASE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !cfgReq.write |=> $stable(stateQ.sel))
      else $error("register changed without a write");

   // Output zero base high sits at 00h
   AST_WRITE_MAP0: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index == `CS_DATA_REG && stateQ.index == `SEL0_BASE_HIGH
      |=> stateQ.sel[0].baseHigh == $past(cfgReq.wrData))
      else $error("base high of output zero not written at its index");

   // Output one base low sits at 05h
   AST_WRITE_MAP1: assert property (@(posedge clk) disable iff (!resetn)
      cfgReq.write && cfgReq.index == `CS_DATA_REG && stateQ.index == `SEL1_BASE_LOW
      |=> stateQ.sel[1].baseLow == $past(cfgReq.wrData))
      else $error("base low of output one not written at its index");

   // An address miss never asserts output zero
   AST_MISS_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      !chip_select_pkg::addrHit(stateQ.pinSync, stateQ.sel[0]) |-> selectOutZeroN)
      else $error("select asserted on an address miss");

   // With no strobe enabled and both strobes idle, output one stays high
   AST_STROBE_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      !stateQ.sel[1].decodeConfig[`CFG_ANY_STROBE] && stateQ.pinSync.rdN
      && stateQ.pinSync.wrN |-> selectOutOneN)
      else $error("select asserted with strobes idle");

   // All four low mask bits drop A3-A0 together
   AST_MASK_A3: assert property (@(posedge clk) disable iff (!resetn)
      !stateQ.pinSync.aen && stateQ.sel[0].decodeConfig[`CFG_ANY_STROBE]
      && stateQ.sel[0].decodeConfig[3:0] == 4'hf
      && stateQ.pinSync.addr[15:4] == {stateQ.sel[0].baseHigh, stateQ.sel[0].baseLow[7:4]}
      |-> !selectOutZeroN)
      else $error("A3-A0 masks did not drop the low lines");

   // A4 is decoded unless bit 7 masks it; low masks never reach it
   AST_A4_KEPT: assert property (@(posedge clk) disable iff (!resetn)
      !stateQ.sel[0].decodeConfig[`CFG_MASK_LOW12]
      && stateQ.pinSync.addr[4] != stateQ.sel[0].baseLow[4] |-> selectOutZeroN)
      else $error("A4 dropped from the compare");

   // Output one follows the same decode as output zero
   AST_SAME_DECODE1: assert property (@(posedge clk) disable iff (!resetn)
      stateQ.sel[1] == stateQ.sel[0] |-> selectOutOneN == selectOutZeroN)
      else $error("output one decodes differently from output zero");

   // Output two also ignores strobes in any-strobe mode
   AST_ANY_STROBE2: assert property (@(posedge clk) disable iff (!resetn)
      chip_select_pkg::addrHit(stateQ.pinSync, stateQ.sel[2]) && !stateQ.pinSync.aen
      && stateQ.sel[2].decodeConfig[`CFG_ANY_STROBE]
      |-> !selectOutTwoN)
      else $error("any-strobe mode of output two did not assert");

   // Top nibble of output two is always compared
   AST_TOP_NIBBLE2: assert property (@(posedge clk) disable iff (!resetn)
      stateQ.pinSync.addr[15:12] != stateQ.sel[2].baseHigh[7:4] |-> selectOutTwoN)
      else $error("top address nibble of output two ignored");

endmodule : programmable_chip_select_decoder

// [include/chip_select_defines.svh]
`ifndef CHIP_SELECT_DEFINES_SVH
`define CHIP_SELECT_DEFINES_SVH

// First-level configuration indexes of the chip-select index and data registers
`define CS_INDEX_REG        8'h23
`define CS_DATA_REG         8'h24

// Second-level indexes: output n owns 4*n+0 .. 4*n+2, 4*n+3 is reserved
`define SEL_COUNT           3
`define SLOT_BASE_HIGH      2'h0
`define SLOT_BASE_LOW       2'h1
`define SLOT_DECODE_CONFIG  2'h2
`define SLOT_RESERVED       2'h3
`define SEL0_BASE_HIGH      4'h0
`define SEL0_BASE_LOW       4'h1
`define SEL0_DECODE_CONFIG  4'h2
`define SEL1_BASE_HIGH      4'h4
`define SEL1_BASE_LOW       4'h5
`define SEL1_DECODE_CONFIG  4'h6
`define SEL2_BASE_HIGH      4'h8
`define SEL2_BASE_LOW       4'h9
`define SEL2_DECODE_CONFIG  4'ha

// Decode configuration bit positions
`define CFG_MASK_A0         0
`define CFG_ON_WRITE        4
`define CFG_ON_READ         5
`define CFG_ANY_STROBE      6
`define CFG_MASK_LOW12      7

// Reset values
`define SEL_REG_RESET       8'h00
`define INDEX_RESET         4'h0
`define READ_PAD            8'h00

`endif

// [include/chip_select_pkg.sv]
`include "chip_select_defines.svh"

package chip_select_pkg;

   // One chip-select output's programmable state
   typedef struct packed {
      logic [7:0] baseHigh;
      logic [7:0] baseLow;
      logic [7:0] decodeConfig;
   } sel_regs_t;

   // Host bus pins that the decoder watches
   typedef struct packed {
      logic [15:0] addr;
      logic        aen;
      logic        rdN;
      logic        wrN;
   } isa_pins_t;

   // Configuration-space access from the device's own config logic
   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] index;
      logic [7:0] wrData;
   } cfg_req_t;

   // Address bits that take part in the compare
   function automatic logic [15:0] careBits(input logic [7:0] cfg);
      logic [15:0] care;
      care = 16'hffff;
      if (cfg[`CFG_MASK_LOW12]) begin
         care[11:0] = 12'h000;
      end
      for (int i = 0; i < 4; i++) begin
         if (cfg[`CFG_MASK_A0 + i]) begin
            care[i] = 1'b0;
         end
      end
      return care;
   endfunction : careBits

   // Unmasked address lines equal the programmed 16-bit base
   function automatic logic addrHit(input isa_pins_t p, input sel_regs_t r);
      return ((p.addr ^ {r.baseHigh, r.baseLow}) & careBits(r.decodeConfig)) == 16'h0000;
   endfunction : addrHit

   // Full qualification of one chip-select, active high
   function automatic logic selectWanted(input isa_pins_t p, input sel_regs_t r);
      logic strobeOk;
      strobeOk = r.decodeConfig[`CFG_ANY_STROBE]
                 | (r.decodeConfig[`CFG_ON_WRITE] & ~p.wrN)
                 | (r.decodeConfig[`CFG_ON_READ] & ~p.rdN);
      return ~p.aen & addrHit(p, r) & strobeOk;
   endfunction : selectWanted

endpackage : chip_select_pkg

// [src/select_gate.sv]
`timescale 1ns/1ps

// One chip-select decoder; the same logic serves every output
module select_gate (
   input  wire chip_select_pkg::isa_pins_t pins,
   input  wire chip_select_pkg::sel_regs_t regs,
   output logic                            selectN
);

   // Pure decode, so the pin reacts in the same cycle as the synchronised bus
   always_comb begin
      selectN = ~chip_select_pkg::selectWanted(pins, regs);
   end

endmodule : select_gate

// [dv/isa_host_model.sv]
`timescale 1ns/1ps

// Host bus master on the decoder's far side; it only drives the watched pins
module isa_host_model (
   input  wire                        clk,
   output chip_select_pkg::isa_pins_t pins
);
   // Bus starts released: no cycle in progress, address enable blocking decode
   initial pins = '{addr: 16'hffff, aen: 1'b1, rdN: 1'b1, wrN: 1'b1};

   // One bus state, launched off the sampling edge so the sync flops never race it
   task automatic busCycle(input logic [15:0] a, input logic aenIn, input logic rdIn,
                           input logic wrIn);
      @(negedge clk);
      pins <= '{addr: a, aen: aenIn, rdN: rdIn, wrN: wrIn};
   endtask : busCycle

   // Released bus: the address floats, so show the inverse rather than a stale match
   task automatic busIdle();
      @(negedge clk);
      pins <= '{addr: ~pins.addr, aen: 1'b1, rdN: 1'b1, wrN: 1'b1};
   endtask : busIdle
endmodule : isa_host_model

// [dv/programmable_chip_select_decoder_tb_top.sv]
`timescale 1ns/1ps

module programmable_chip_select_decoder_tb_top;
   logic                       clk;
   logic                       resetn;
   chip_select_pkg::cfg_req_t  cfgReq;
   chip_select_pkg::isa_pins_t isaPins;
   logic [7:0]                 cfgRdData;
   logic                       cfgRdValid;
   logic                       selectOutZeroN;
   logic                       selectOutOneN;
   logic                       selectOutTwoN;
   logic [2:0]                 selN;
   int                         n_errors;
   int                         checks;
   logic [15:0] bases  [3]  = '{16'h1234, 16'h2234, 16'h3a5c};
   logic [15:0] probes [8]  = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
                                16'h0008, 16'h0010, 16'h0800, 16'h1000};
   logic [7:0]  cfgRows [12] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h70,
                                 8'h41, 8'h42, 8'h44, 8'h48, 8'h1f, 8'hc0};
   // Reserved slots 3, 7 and Bh-Fh are left alone: software must not touch them
   logic [3:0]  regIdx [9]  = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};

   assign selN = {selectOutTwoN, selectOutOneN, selectOutZeroN};

   programmable_chip_select_decoder dut (
      .clk           (clk),
      .resetn        (resetn),
      .cfgReq        (cfgReq),
      .isaPins       (isaPins),
      .cfgRdData     (cfgRdData),
      .cfgRdValid    (cfgRdValid),
      .selectOutZeroN(selectOutZeroN),
      .selectOutOneN (selectOutOneN),
      .selectOutTwoN (selectOutTwoN)
   );

   isa_host_model u_host (
      .clk (clk),
      .pins(isaPins)
   );

   // Free-running 100 MHz clock
   always #5 clk = ~clk;

   task automatic close_out();
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One-cycle write pulse; the next call lets an edge pass before raising it again
   task automatic cfgWrite(input logic [7:0] idx, input logic [7:0] d);
      @(negedge clk);
      cfgReq.write  <= 1'b1;
      cfgReq.index  <= idx;
      cfgReq.wrData <= d;
      @(negedge clk);
      cfgReq.write  <= 1'b0;
   endtask : cfgWrite

   // Read pulse; valid must already be up in the cycle after the taking edge
   task automatic cfgRead(input logic [7:0] idx, input logic [7:0] exp);
      int n;
      @(negedge clk);
      cfgReq.read  <= 1'b1;
      cfgReq.index <= idx;
      @(negedge clk);
      cfgReq.read  <= 1'b0;
      n = 0;
      while (cfgRdValid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (n == 4) begin
         n_errors++;
         close_out();
      end
      check(16'(n), 16'h0000);
      check({8'h00, cfgRdData}, {8'h00, exp});
   endtask : cfgRead

   // Reference decode, active high, built independently of the design's helpers
   function automatic logic expSel(input logic [15:0] a, input logic aen, input logic rdN,
                                   input logic wrN, input logic [15:0] base,
                                   input logic [7:0] c);
      logic [15:0] care;
      care      = c[7] ? 16'hf000 : 16'hffff;
      care[3:0] = care[3:0] & ~c[3:0];
      return !aen && (((a ^ base) & care) == 16'h0000)
             && (c[6] || (c[4] && !wrN) || (c[5] && !rdN));
   endfunction : expSel

   function automatic logic [7:0] dataFor(input logic [3:0] idx);
      return 8'h3c ^ {idx, idx};
   endfunction : dataFor

   initial begin
      logic [15:0] a;
      logic        aenV;
      logic        rdV;
      logic        wrV;
      clk      = 1'b0;
      resetn   = 1'b0;
      cfgReq   = '0;
      n_errors = 0;
      checks   = 0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      check({13'h0000, selN}, 16'h0007);
      cfgRead(8'h23, 8'h00);
      // Every register clears to zero and answers through the data index
      for (int i = 0; i < 9; i++) begin
         cfgWrite(8'h23, {4'h0, regIdx[i]});
         cfgRead(8'h24, 8'h00);
      end
      // Fill all slots first, then read back, so aliasing between slots shows
      for (int i = 0; i < 9; i++) begin
         cfgWrite(8'h23, {4'h0, regIdx[i]});
         cfgWrite(8'h24, dataFor(regIdx[i]));
      end
      for (int i = 0; i < 9; i++) begin
         cfgWrite(8'h23, {4'h0, regIdx[i]});
         cfgRead(8'h24, dataFor(regIdx[i]));
      end
      cfgWrite(8'h23, 8'hf6);
      cfgRead(8'h23, 8'h06);
      cfgRead(8'h24, dataFor(4'h6));
      // Distinct 16-bit bases that differ in the top nibble too
      for (int k = 0; k < 3; k++) begin
         cfgWrite(8'h23, 8'(4 * k));
         cfgWrite(8'h24, bases[k][15:8]);
         cfgWrite(8'h23, 8'(4 * k + 1));
         cfgWrite(8'h24, bases[k][7:0]);
      end
      // Same decode setting on all three outputs, probes around each base
      for (int r = 0; r < 12; r++) begin
         for (int k = 0; k < 3; k++) begin
            cfgWrite(8'h23, 8'(4 * k + 2));
            cfgWrite(8'h24, cfgRows[r]);
         end
         for (int t = 0; t < 3; t++) begin
            for (int p = 0; p < 8; p++) begin
               for (int s = 0; s < 4; s++) begin
                  a    = bases[t] ^ probes[p];
                  aenV = (s == 3);
                  rdV  = !(s == 0 || s == 3);
                  wrV  = !(s == 1);
                  u_host.busCycle(a, aenV, rdV, wrV);
                  // Sync latency is two edges; three leaves margin for the launch edge
                  repeat (3) @(negedge clk);
                  for (int q = 0; q < 3; q++) begin
                     check({15'h0000, selN[q]}, {15'h0000, ~expSel(a, aenV, rdV, wrV, bases[q], cfgRows[r])});
                  end
               end
            end
         end
      end
      u_host.busIdle();
      repeat (3) @(negedge clk);
      check({13'h0000, selN}, 16'h0007);
      cfgRead(8'h2f, 8'h00);
      // Second reset mid-run: registers must clear again
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      check({13'h0000, selN}, 16'h0007);
      cfgRead(8'h23, 8'h00);
      cfgWrite(8'h23, 8'h02);
      cfgRead(8'h24, 8'h00);
      close_out();
   end
endmodule : programmable_chip_select_decoder_tb_top
